// File: dcsd_consts.svh
/*
  constants for the diskette command, status and drive-line block:
  opcodes, status bit positions and timing.
  assumes the system clock of DCSD_CLK_MHZ.
*/
`ifndef DCSD_CONSTS_SVH
`define DCSD_CONSTS_SVH
// ----------------------------------------
// clock and times
// ----------------------------------------
`define DCSD_CLK_MHZ 20
`define DCSD_CYC_UP(ns) (((ns) * `DCSD_CLK_MHZ + 999) / 1000)
`define DCSD_CYC_DN(ns) (((ns) * `DCSD_CLK_MHZ) / 1000)
`define DCSD_STEP_MIN_NS 1000
`define DCSD_DIR_HOLD_NS 1000
`define DCSD_WE_LEAD_NS 8000
`define DCSD_WPULSE_NS 250
`define DCSD_PRECOMP_NS 125
`define DCSD_STEP_UNIT_NS 1000000
// ----------------------------------------
// opcodes
// ----------------------------------------
`define DCSD_OP_SENSE_INT 8'h08
`define DCSD_OP_SPECIFY 8'h03
`define DCSD_OP_SENSE_DRV 8'h04
`define DCSD_OP_SEEK 8'h0f
`define DCSD_OP_RECAL 8'h07
// ----------------------------------------
// status fields and values
// ----------------------------------------
`define DCSD_TC_NORMAL 2'h0
`define DCSD_TC_ABRUPT 2'h1
`define DCSD_TC_INVALID 2'h2
`define DCSD_TC_READY_CHG 2'h3
`define DCSD_ST0_SEEK_END 5
`define DCSD_ST0_EQUIP 4
`define DCSD_ST0_NOT_READY 3
`define DCSD_RECAL_MAX 7'h4d
`define DCSD_ST_RESET 8'h00
`endif

// File: dcsd_pkg.sv
/*
  types for the diskette command, status and drive-line block.
  assumes nothing beyond the constants header.
*/
`default_nettype none
package dcsd_pkg;
  typedef enum logic [1:0] {CS_IDLE, CS_ARG, CS_RES} dcsd_cmd_state_t;
  typedef enum logic [2:0] {MV_IDLE, MV_CHECK, MV_DIR, MV_PULSE, MV_GAP} dcsd_move_state_t;
endpackage
`default_nettype wire

// File: dcsd_cmd_status_drive.sv
/*
  command interpreter, status bytes and drive-line control of a diskette
  controller: sense interrupt, specify, sense drive, seek, recalibrate and
  invalid commands; step, direction, select, write enable and write data.
  assumes a byte-wide command/result handshake on clk_sys and a separate
  data-transfer engine that reports its errors as one-cycle event pulses.
*/
// Functional notes
// - sense interrupt is 08h; answers status byte then present cylinder
// - specify stores step rate, unload and load times and non-data flag
// - sense drive is 04h plus head/unit byte; answers drive status byte
// - specify and seek give no result; new command accepted at once
// - unknown opcode answers one byte with termination code 10, nothing starts
// - bits 7:6 termination: 00 normal, 01 failed, 11 ready changed
// - seek completion sets bit 5 of termination byte
// - drive fault or no track zero after 77 steps sets bit 4
// - not ready at read/write sets bit 3; head and unit in 2:0
// - access past last sector sets error byte bit 7
// - crc error sets bit 5, overrun bit 4; bits 6 and 3 reserved
// - sector not found or bad id field sets error byte bit 2
// - write protect during write or format sets error byte bit 1
// - missing id mark sets error bit 0 and data-check bit 0
// - deleted-data mark sets data-check bit 6; bit 7 reads zero
// - cylinder mismatch sets data-check bit 4; mismatch or ffh sets bit 1
// - scan equal hit sets bit 3; scan not satisfied sets bit 2
// - data field error sets bit 5; missing data mark sets bit 0
// - drive status byte mirrors fault, wp, ready, trk0, two-side, head, selects
// - step pulse at least 1 us; direction stable 1 us around trailing edge
// - write enable 8 us before data; 250 ns pulses; 125 ns precompensation (code rounds down to PC = 2 cycles, 100 ns)
`default_nettype none
`include "dcsd_consts.svh"
module dcsd_cmd_status_drive #(
  parameter int unsigned STEP_UNIT_CYC = `DCSD_CYC_DN(`DCSD_STEP_UNIT_NS)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmdWr,
  input wire logic [7:0] cmdData,
  output logic cmdReady_r,
  output logic resValid_r,
  output logic [7:0] resData_r,
  input wire logic resAck,
  output logic intReq_r,
  output logic [3:0] stepRateTime_r,
  output logic [3:0] headUnloadTime_r,
  output logic [6:0] headLoadTime_r,
  output logic nonDataMode_r,
  output logic [7:0] termStatus_r,
  output logic [7:0] xferError_r,
  output logic [7:0] dataCheck_r,
  output logic [7:0] driveLine_r,
  input wire logic xferStart,
  input wire logic evEndCyl,
  input wire logic evCrcErr,
  input wire logic evOverrun,
  input wire logic evNoData,
  input wire logic evWrProt,
  input wire logic evNoIdMark,
  input wire logic evDeleted,
  input wire logic evDataErr,
  input wire logic evWrongCyl,
  input wire logic evBadCyl,
  input wire logic evScanHit,
  input wire logic evScanMiss,
  input wire logic evNoDataMark,
  input wire logic wrGate,
  input wire logic wrBit,
  input wire logic [1:0] wrPrecomp,
  input wire logic driveFault,
  input wire logic writeProtN,
  input wire logic driveReady,
  input wire logic track0N,
  input wire logic twoSided,
  output logic stepN_r,
  output logic directionN_r,
  output logic head1SelN_r,
  output logic [1:0] driveSelN_r,
  output logic writeEnN_r,
  output logic writeDataN_r
);
  import dcsd_pkg::*;

  localparam logic [4:0] DIR_CYC = 5'(`DCSD_CYC_UP(`DCSD_DIR_HOLD_NS));
  localparam logic [4:0] STEP_CYC = 5'(`DCSD_CYC_UP(`DCSD_STEP_MIN_NS));
  localparam logic [7:0] WE_CYC = 8'(`DCSD_CYC_UP(`DCSD_WE_LEAD_NS));
  localparam logic [2:0] WP_CYC = 3'(`DCSD_CYC_UP(`DCSD_WPULSE_NS));
  localparam int PC = `DCSD_CYC_DN(`DCSD_PRECOMP_NS);
  localparam int PL = 2 * PC + 1;

  // ----------------------------------------
  // drive line synchronisers
  // ----------------------------------------
  logic [4:0] rawIn;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  assign rawIn = {driveFault, ~writeProtN, driveReady, ~track0N, twoSided};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= rawIn[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  wire faultS = sync2_r[4];
  wire readyS = sync2_r[2];
  wire trk0S = sync2_r[1];

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // extra bytes that follow each opcode
  function automatic logic [1:0] argsFor(input logic [7:0] op);
    unique case (op)
      `DCSD_OP_SPECIFY, `DCSD_OP_SEEK: argsFor = 2'd2;
      `DCSD_OP_SENSE_DRV, `DCSD_OP_RECAL: argsFor = 2'd1;
      default: argsFor = 2'd0;
    endcase
  endfunction

  dcsd_cmd_state_t cmdState_r;
  logic [7:0] opcode_r;
  logic [7:0] arg1_r;
  logic [1:0] argLeft_r;
  logic [1:0] resLeft_r;
  logic [7:0] resNext_r;
  logic [7:0] pcn_r [0:3];
  logic [1:0] unit_r;

  wire cmdTake = cmdWr && cmdReady_r;
  wire idleTake = cmdTake && (cmdState_r == CS_IDLE);
  wire lastByte = idleTake ? (argsFor(cmdData) == 2'd0)
                           : (cmdTake && argLeft_r == 2'd1);
  wire [7:0] execOp = (cmdState_r == CS_IDLE) ? cmdData : opcode_r;
  wire doSenseInt = lastByte && execOp == `DCSD_OP_SENSE_INT;
  wire doSpecify = lastByte && execOp == `DCSD_OP_SPECIFY;
  wire doSenseDrv = lastByte && execOp == `DCSD_OP_SENSE_DRV;
  wire doSeek = lastByte && execOp == `DCSD_OP_SEEK;
  wire doRecal = lastByte && execOp == `DCSD_OP_RECAL;
  wire doInvalid = lastByte && argsFor(execOp) == 2'd0 && !doSenseInt;
  wire moveStart = doSeek || doRecal;
  wire [7:0] st3Now = {faultS, sync2_r[3], readyS, trk0S, sync2_r[0],
                       ~head1SelN_r, ~driveSelN_r[1], ~driveSelN_r[0]};

  // command byte collection and result delivery
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmdState_r <= CS_IDLE;
      opcode_r <= `DCSD_ST_RESET;
      arg1_r <= `DCSD_ST_RESET;
      argLeft_r <= 2'd0;
      resLeft_r <= 2'd0;
      resData_r <= `DCSD_ST_RESET;
      resNext_r <= `DCSD_ST_RESET;
    end else if (lastByte) begin
      resNext_r <= pcn_r[termStatus_r[1:0]];
      if (doSenseInt) begin
        resData_r <= termStatus_r;
        resLeft_r <= 2'd2;
        cmdState_r <= CS_RES;
      end else if (doSenseDrv) begin
        resData_r <= {st3Now[7:3], ~cmdData[2] ? 1'b0 : 1'b1, cmdData[1:0]};
        resLeft_r <= 2'd1;
        cmdState_r <= CS_RES;
      end else if (doInvalid) begin
        resData_r <= {`DCSD_TC_INVALID, 6'h00};
        resLeft_r <= 2'd1;
        cmdState_r <= CS_RES;
      end else begin
        cmdState_r <= CS_IDLE;
      end
    end else if (idleTake) begin
      opcode_r <= cmdData;
      argLeft_r <= argsFor(cmdData);
      cmdState_r <= CS_ARG;
    end else if (cmdTake) begin
      arg1_r <= cmdData;
      argLeft_r <= argLeft_r - 2'd1;
    end else if (cmdState_r == CS_RES && resAck) begin
      resData_r <= resNext_r;
      resLeft_r <= resLeft_r - 2'd1;
      if (resLeft_r == 2'd1) cmdState_r <= CS_IDLE;
    end
  end

  // ready for a byte while collecting; result byte valid while delivering
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmdReady_r <= 1'b0;
      resValid_r <= 1'b0;
    end else begin
      cmdReady_r <= (cmdState_r != CS_RES) && !(doSenseInt || doSenseDrv || doInvalid)
                    || (cmdState_r == CS_RES && resAck && resLeft_r == 2'd1);
      resValid_r <= (cmdState_r == CS_RES) ? !(resAck && resLeft_r == 2'd1)
                    : (doSenseInt || doSenseDrv || doInvalid);
    end
  end

  // specify values held for later drive operations
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stepRateTime_r <= 4'h0;
      headUnloadTime_r <= 4'h0;
      headLoadTime_r <= 7'h00;
      nonDataMode_r <= 1'b0;
    end else if (doSpecify) begin
      stepRateTime_r <= arg1_r[7:4];
      headUnloadTime_r <= arg1_r[3:0];
      headLoadTime_r <= cmdData[7:1];
      nonDataMode_r <= cmdData[0];
    end
  end

  // ----------------------------------------
  // head motion: seek and recalibrate
  // ----------------------------------------
  dcsd_move_state_t mvState_r;
  logic [19:0] timer_r;
  logic [7:0] target_r;
  logic recal_r;
  logic readyAtStart_r;
  logic [6:0] stepCnt_r;
  wire timerDone = (timer_r == 20'h0);
  wire [7:0] pcnSel = pcn_r[unit_r];
  wire [19:0] gapCyc = 20'((5'h10 - {1'b0, stepRateTime_r}) * STEP_UNIT_CYC);
  wire mvFault = faultS;
  wire mvReadyChg = readyS != readyAtStart_r;
  wire mvRecalFail = recal_r && !trk0S && stepCnt_r == `DCSD_RECAL_MAX;
  wire mvArrived = recal_r ? trk0S : (pcnSel == target_r);
  wire mvCheck = (mvState_r == MV_CHECK);
  wire mvFinish = mvCheck && (mvFault || mvReadyChg || mvRecalFail || mvArrived);
  wire [1:0] mvCode = mvReadyChg ? `DCSD_TC_READY_CHG
                    : (mvFault || mvRecalFail) ? `DCSD_TC_ABRUPT : `DCSD_TC_NORMAL;
  wire mvUp = !recal_r && (target_r > pcnSel);

  // step sequencing: direction settle, pulse, rate gap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mvState_r <= MV_IDLE;
      timer_r <= 20'h0;
      stepN_r <= 1'b1;
      directionN_r <= 1'b1;
      stepCnt_r <= 7'h00;
    end else if (moveStart) begin
      mvState_r <= MV_CHECK;
      stepN_r <= 1'b1;
      stepCnt_r <= 7'h00;
    end else begin
      if (!timerDone) timer_r <= timer_r - 20'h1;
      unique case (mvState_r)
        MV_IDLE: mvState_r <= MV_IDLE;
        MV_CHECK: begin
          if (mvFinish) begin
            mvState_r <= MV_IDLE;
          end else begin
            directionN_r <= ~mvUp;
            timer_r <= 20'(DIR_CYC);
            mvState_r <= MV_DIR;
          end
        end
        MV_DIR: if (timerDone) begin
          stepN_r <= 1'b0;
          timer_r <= 20'(STEP_CYC);
          mvState_r <= MV_PULSE;
        end
        MV_PULSE: if (timerDone) begin
          stepN_r <= 1'b1;
          stepCnt_r <= stepCnt_r + 7'h1;
          timer_r <= gapCyc;
          mvState_r <= MV_GAP;
        end
        MV_GAP: if (timerDone) mvState_r <= MV_CHECK;
      endcase
    end
  end

  // present cylinder per unit, target and selection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) pcn_r[i] <= 8'h00;
      target_r <= 8'h00;
      recal_r <= 1'b0;
      readyAtStart_r <= 1'b0;
      unit_r <= 2'h0;
      driveSelN_r <= 2'h3;
      head1SelN_r <= 1'b1;
    end else begin
      if (moveStart) begin
        unit_r <= doSeek ? arg1_r[1:0] : cmdData[1:0];
        target_r <= doSeek ? cmdData : 8'h00;
        recal_r <= doRecal;
        readyAtStart_r <= readyS;
        driveSelN_r <= ~(doSeek ? arg1_r[1:0] : cmdData[1:0]);
        head1SelN_r <= 1'b1;
      end else if (doSenseDrv) begin
        driveSelN_r <= ~cmdData[1:0];
        head1SelN_r <= ~cmdData[2];
      end
      if (mvCheck && recal_r && trk0S) pcn_r[unit_r] <= 8'h00;
      else if (mvState_r == MV_PULSE && timerDone)
        pcn_r[unit_r] <= directionN_r ? pcnSel - 8'h1 : pcnSel + 8'h1;
    end
  end

  // ----------------------------------------
  // status bytes and interrupt request
  // ----------------------------------------
  wire notReadyHit = xferStart && !readyS;
  wire [7:0] st1Ev = {evEndCyl, 1'b0, evCrcErr, evOverrun, 1'b0,
                      evNoData, evWrProt, evNoIdMark};
  wire [7:0] st2Ev = {1'b0, evDeleted, evDataErr, evWrongCyl,
                      evScanHit, evScanMiss, evBadCyl,
                      evNoDataMark || evNoIdMark};

  // error bytes clear at transfer start; an event in the same cycle still lands
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      termStatus_r <= `DCSD_ST_RESET;
      xferError_r <= `DCSD_ST_RESET;
      dataCheck_r <= `DCSD_ST_RESET;
      driveLine_r <= `DCSD_ST_RESET;
      intReq_r <= 1'b0;
    end else begin
      xferError_r <= (xferStart ? 8'h00 : xferError_r) | st1Ev;
      dataCheck_r <= (xferStart ? 8'h00 : dataCheck_r) | st2Ev;
      driveLine_r <= st3Now;
      if (mvFinish) begin
        termStatus_r <= {mvCode, 1'b1,
                         mvFault || mvRecalFail,
                         1'b0, 1'b0, unit_r};
      end else if (notReadyHit) begin
        termStatus_r <= {`DCSD_TC_ABRUPT, 1'b0, 1'b0, 1'b1,
                         ~head1SelN_r, ~driveSelN_r};
      end
      intReq_r <= mvFinish || (intReq_r && !doSenseInt);
    end
  end

  // ----------------------------------------
  // write enable and write data pulses
  // ----------------------------------------
  logic [7:0] weCnt_r;
  logic [PL-1:0] wpPipe_r;
  logic [2:0] wpCnt_r;
  wire weOk = (weCnt_r == WE_CYC);
  wire bitGo = wrBit && wrGate && weOk;
  wire [PL-1:0] bitIns = !bitGo ? '0
                       : (wrPrecomp == 2'h1) ? PL'(1) << (PL - 1)
                       : (wrPrecomp == 2'h2) ? PL'(1) : PL'(1) << (PL - 1 - PC);

  // precompensation code 1 moves a pulse PC cycles early, code 2 PC cycles late
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      weCnt_r <= 8'h00;
      writeEnN_r <= 1'b1;
      wpPipe_r <= '0;
      wpCnt_r <= 3'h0;
      writeDataN_r <= 1'b1;
    end else begin
      writeEnN_r <= ~wrGate;
      weCnt_r <= !wrGate ? 8'h00 : (weOk ? weCnt_r : weCnt_r + 8'h1);
      wpPipe_r <= {wpPipe_r[PL-2:0], 1'b0} | bitIns;
      if (wpPipe_r[PL-1]) wpCnt_r <= WP_CYC;
      else if (wpCnt_r != 3'h0) wpCnt_r <= wpCnt_r - 3'h1;
      writeDataN_r <= !(wpPipe_r[PL-1] || wpCnt_r > 3'h1);
    end
  end
endmodule
`default_nettype wire

// File: dcsd_cmd_status_drive_properties.sv
/*
  concurrent checks for the diskette command, status and drive-line block.
  assumes a bind to the top module ports, one clock clk_sys.
*/
`default_nettype none
module dcsd_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmdWr,
  input wire logic [7:0] cmdData,
  input wire logic cmdReady_r,
  input wire logic resValid_r,
  input wire logic [7:0] resData_r,
  input wire logic intReq_r,
  input wire logic [6:0] headLoadTime_r,
  input wire logic nonDataMode_r,
  input wire logic [7:0] termStatus_r,
  input wire logic [7:0] dataCheck_r,
  input wire logic stepN_r,
  input wire logic directionN_r,
  input wire logic writeEnN_r,
  input wire logic writeDataN_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] argLeft_r;
  logic [7:0] op_r;
  logic [7:0] lowCnt_r;
  logic [7:0] stepAge_r;
  logic [9:0] weAge_r;
  // ----------------------------------------
  // command byte tracking
  // ----------------------------------------
  // byte taken, opcode byte, known opcode, argument bytes to come
  wire logic taken = cmdWr && cmdReady_r;
  wire logic first = taken && argLeft_r == 2'h0;
  wire logic known = cmdData == 8'h08 || cmdData == 8'h03 || cmdData == 8'h04 ||
    cmdData == 8'h0f || cmdData == 8'h07;
  wire logic [1:0] argNew = (cmdData == 8'h03 || cmdData == 8'h0f) ? 2'h2 :
    (cmdData == 8'h04 || cmdData == 8'h07) ? 2'h1 : 2'h0;
  wire logic lastArg = taken && argLeft_r == 2'h1;
  // byte position and saturating timers of the drive lines
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      argLeft_r <= 2'h0;
      op_r <= 8'h00;
      lowCnt_r <= 8'h00;
      stepAge_r <= 8'hff;
      weAge_r <= 10'h000;
    end else begin
      argLeft_r <= !taken ? argLeft_r : first ? argNew : argLeft_r - 2'h1;
      op_r <= first ? cmdData : op_r;
      lowCnt_r <= stepN_r ? 8'h00 : lowCnt_r + {7'h0, lowCnt_r != 8'hff};
      stepAge_r <= !stepN_r ? 8'h00 : stepAge_r + {7'h0, stepAge_r != 8'hff};
      weAge_r <= writeEnN_r ? 10'h000 : weAge_r + {9'h0, weAge_r != 10'h3ff};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_sense; first && cmdData == 8'h08 |=> resValid_r && !cmdReady_r; endproperty
  a_sense: assert property (p_sense) else $error("no sense answer");
  property p_inval; first && !known |=> resValid_r && resData_r == 8'h80; endproperty
  a_inval: assert property (p_inval) else $error("bad invalid answer");
  property p_nores;
    lastArg && (op_r == 8'h03 || op_r == 8'h0f) |=> !resValid_r && cmdReady_r;
  endproperty
  a_nores: assert property (p_nores) else $error("unexpected result");
  property p_spec;
    lastArg && op_r == 8'h03 |=> $past(cmdData) == {headLoadTime_r, nonDataMode_r};
  endproperty
  a_spec: assert property (p_spec) else $error("specify not kept");
  property p_sdrv;
    lastArg && op_r == 8'h04 |=> resValid_r && ($past(cmdData) & 8'h07) == {5'h0, resData_r[2:0]};
  endproperty
  a_sdrv: assert property (p_sdrv) else $error("drive status head/unit");
  property p_dc7; dataCheck_r[7] == 1'b0; endproperty
  a_dc7: assert property (p_dc7) else $error("reserved bit set");
  property p_intse; $rose(intReq_r) |-> termStatus_r[5]; endproperty
  a_intse: assert property (p_intse) else $error("seek end missing");
  property p_stepw; $rose(stepN_r) |-> lowCnt_r >= 8'd20; endproperty
  a_stepw: assert property (p_stepw) else $error("step pulse short");
  property p_dir; $changed(directionN_r) |-> stepN_r && stepAge_r >= 8'd20; endproperty
  a_dir: assert property (p_dir) else $error("direction moved near step");
  property p_welead; $fell(writeDataN_r) |-> weAge_r >= 10'd160; endproperty
  a_welead: assert property (p_welead) else $error("write enable late");
  property p_wpulse; $fell(writeDataN_r) |-> !writeDataN_r [*5] ##1 writeDataN_r; endproperty
  a_wpulse: assert property (p_wpulse) else $error("write pulse width");
  c_sense: cover property (first && cmdData == 8'h08);
  c_int: cover property ($rose(intReq_r));
  c_write: cover property ($fell(writeDataN_r));
endmodule
`default_nettype wire

// File: dcsd_drive_model.sv
/*
  behavioural diskette drive answering drive select line 0.
  assumes active-low step, direction, select and write lines.
*/
`default_nettype none
module dcsd_drive_model (
  input wire logic stepN,
  input wire logic directionN,
  input wire logic [1:0] driveSelN,
  input wire logic writeEnN,
  input wire logic writeDataN,
  input wire logic wpOn,
  input wire logic noTrk0,
  output logic track0N,
  output logic writeProtN,
  output logic diskChangeN,
  output var int cyl,
  output var int steps,
  output var int writes
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // head motion and media
  // ----------------------------------------
  initial begin
    cyl = 0;
    steps = 0;
    writes = 0;
    diskChangeN = 1'b0;
  end
  // one track per trailing edge, direction sampled there, selected only
  always @(posedge stepN) begin
    if (driveSelN[0] === 1'b0) begin
      steps++;
      diskChangeN = 1'b1; // change line held until a step
      if (directionN === 1'b0) cyl++;
      else if (cyl > 0) cyl--;
    end
  end
  // a written one counts only with write current on
  always @(negedge writeDataN) begin
    if (writeEnN === 1'b0) writes++;
  end
  // status lines, track zero can be hidden to fake a missing drive
  assign track0N = !(cyl == 0 && !noTrk0);
  assign writeProtN = !wpOn;
endmodule
`default_nettype wire

// File: dcsd_cmd_status_drive_tb.sv
/*
  self-checking bench for the diskette command, status and drive-line block.
  assumes the drive model and the checker are compiled first.
*/
`default_nettype none
module dcsd_cmd_status_drive_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmdWr = 1'b0, resAck = 1'b0, xferStart = 1'b0, wrGate = 1'b0, wrBit = 1'b0;
  logic wpOn = 1'b0, noTrk0 = 1'b0, ready = 1'b1, fault = 1'b0, twoSided = 1'b1;
  logic [7:0] cmdData = 8'h00;
  logic [1:0] wrPrecomp = 2'h0;
  logic [12:0] ev = 13'h0;
  logic cmdReady_r, resValid_r, intReq_r, nonDataMode_r, track0N, writeProtN;
  logic stepN_r, directionN_r, head1SelN_r, writeEnN_r, writeDataN_r;
  logic [1:0] driveSelN_r;
  logic [3:0] stepRateTime_r, headUnloadTime_r;
  logic [6:0] headLoadTime_r;
  logic [7:0] resData_r, termStatus_r, xferError_r, dataCheck_r, driveLine_r;
  int cyl, steps, writes, s0, mismatches = 0, nCompared = 0, cycles = 0;
  logic [7:0] badOps [3] = '{8'h00, 8'h06, 8'hff};
  logic [7:0] tgt [2] = '{8'h03, 8'h00};
  logic [15:0] evExp [13] = '{16'h8000, 16'h2000, 16'h1000, 16'h0400, 16'h0200, 16'h0101,
    16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
  // ----------------------------------------
  // design, drive and clock
  // ----------------------------------------
  dcsd_cmd_status_drive #(.STEP_UNIT_CYC(20)) i_dcsd_cmd_status_drive (
    .clk_sys(clk_sys), .reset(reset), .cmdWr(cmdWr), .cmdData(cmdData),
    .cmdReady_r(cmdReady_r), .resValid_r(resValid_r), .resData_r(resData_r),
    .resAck(resAck), .intReq_r(intReq_r), .stepRateTime_r(stepRateTime_r),
    .headUnloadTime_r(headUnloadTime_r), .headLoadTime_r(headLoadTime_r),
    .nonDataMode_r(nonDataMode_r), .termStatus_r(termStatus_r), .xferError_r(xferError_r),
    .dataCheck_r(dataCheck_r), .driveLine_r(driveLine_r), .xferStart(xferStart),
    .evEndCyl(ev[0]), .evCrcErr(ev[1]), .evOverrun(ev[2]), .evNoData(ev[3]),
    .evWrProt(ev[4]), .evNoIdMark(ev[5]), .evDeleted(ev[6]), .evDataErr(ev[7]),
    .evWrongCyl(ev[8]), .evScanHit(ev[9]), .evScanMiss(ev[10]), .evBadCyl(ev[11]),
    .evNoDataMark(ev[12]), .wrGate(wrGate), .wrBit(wrBit), .wrPrecomp(wrPrecomp),
    .driveFault(fault), .writeProtN(writeProtN), .driveReady(ready), .track0N(track0N),
    .twoSided(twoSided), .stepN_r(stepN_r), .directionN_r(directionN_r),
    .head1SelN_r(head1SelN_r), .driveSelN_r(driveSelN_r), .writeEnN_r(writeEnN_r),
    .writeDataN_r(writeDataN_r));
  dcsd_drive_model i_dcsd_drive_model (
    .stepN(stepN_r), .directionN(directionN_r), .driveSelN(driveSelN_r),
    .writeEnN(writeEnN_r), .writeDataN(writeDataN_r), .wpOn(wpOn), .noTrk0(noTrk0),
    .track0N(track0N), .writeProtN(writeProtN), .diskChangeN(), .cyl(cyl),
    .steps(steps), .writes(writes));
  always #25 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      reportAndStop;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one command byte once the port is ready
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmdReady_r !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    cmdWr <= 1'b1;
    cmdData <= b;
    @(posedge clk_sys);
    cmdWr <= 1'b0;
  endtask
  // one result byte, masked compare, then acknowledge
  task automatic get(input logic [7:0] e, input logic [7:0] m);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (resValid_r !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk("result", {8'h01, e}, {7'h0, resValid_r, resData_r & m});
    @(posedge clk_sys);
    resAck <= 1'b1;
    @(posedge clk_sys);
    resAck <= 1'b0;
  endtask
  task automatic waitInt(input int lim);
    int n;
    n = 0;
    while (intReq_r !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk("interrupt", 16'h1, {15'h0, intReq_r});
  endtask
  task automatic reportAndStop;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("reset status", 16'h0, {xferError_r | termStatus_r, dataCheck_r});
    chk("reset lines", 16'hfe, {stepN_r, directionN_r, head1SelN_r, driveSelN_r,
      writeEnN_r, writeDataN_r, intReq_r});
    foreach (badOps[i]) begin
      put(badOps[i]);
      get(8'h80, 8'hff);
    end
    put(8'h03);
    put(8'hf5);
    put(8'h07);
    @(negedge clk_sys);
    chk("specify", 16'hf507, {stepRateTime_r, headUnloadTime_r, headLoadTime_r,
      nonDataMode_r});
    chk("no result", 16'h1, {14'h0, resValid_r, cmdReady_r});
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      wpOn <= (i == 0);
      repeat (4) @(posedge clk_sys);
      put(8'h04);
      put(i == 0 ? 8'h05 : 8'h02);
      get(i == 0 ? 8'h7d : 8'h3a, 8'hff);
    end
    chk("drive lines", 16'h3a, {8'h0, driveLine_r});
    foreach (tgt[i]) begin
      put(8'h0f);
      put(8'h01);
      put(tgt[i]);
      @(negedge clk_sys);
      chk("no result", 16'h1, {14'h0, resValid_r, cmdReady_r});
      waitInt(3000);
      chk("cylinder", {8'h0, tgt[i]}, cyl[15:0]);
      put(8'h08);
      get(8'h21, 8'hff);
      get(tgt[i], 8'hff);
      @(negedge clk_sys);
      chk("interrupt", 16'h0, {15'h0, intReq_r});
    end
    @(posedge clk_sys);
    noTrk0 <= 1'b1;
    s0 = steps;
    put(8'h07);
    put(8'h01);
    waitInt(8000);
    chk("recal steps", 16'd77, 16'(steps - s0));
    put(8'h08);
    get(8'h71, 8'hff);
    get(8'h00, 8'h00);
    @(posedge clk_sys);
    noTrk0 <= 1'b0;
    ready <= 1'b0;
    repeat (4) @(posedge clk_sys);
    xferStart <= 1'b1;
    @(posedge clk_sys);
    xferStart <= 1'b0;
    ready <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("not ready", 16'h09, {11'h0, termStatus_r[7:3]});
    for (int i = 0; i < 13; i++) begin
      @(posedge clk_sys);
      ev <= 13'h1 << i;
      @(posedge clk_sys);
      ev <= 13'h0;
      @(negedge clk_sys);
      chk("error bytes", evExp[i], {xferError_r, dataCheck_r});
      @(posedge clk_sys);
      xferStart <= 1'b1;
      @(posedge clk_sys);
      xferStart <= 1'b0;
    end
    wrGate <= 1'b1;
    repeat (170) @(posedge clk_sys);
    for (int p = 0; p < 3; p++) begin
      wrBit <= 1'b1;
      wrPrecomp <= 2'(p);
      @(posedge clk_sys);
      wrBit <= 1'b0;
      repeat (80) @(posedge clk_sys);
    end
    wrGate <= 1'b0;
    @(negedge clk_sys);
    chk("write pulses", 16'h3, writes[15:0]);
    reportAndStop;
  end
endmodule
bind dcsd_cmd_status_drive dcsd_checker i_dcsd_checker (
  .clk_sys(clk_sys), .reset(reset), .cmdWr(cmdWr), .cmdData(cmdData),
  .cmdReady_r(cmdReady_r), .resValid_r(resValid_r), .resData_r(resData_r),
  .intReq_r(intReq_r), .headLoadTime_r(headLoadTime_r), .nonDataMode_r(nonDataMode_r),
  .termStatus_r(termStatus_r), .dataCheck_r(dataCheck_r), .stepN_r(stepN_r),
  .directionN_r(directionN_r), .writeEnN_r(writeEnN_r), .writeDataN_r(writeDataN_r));
`default_nettype wire
